// *** uart_pkg.sv ***
package uart_pkg;

	// ------------------------------------------------------------
	// Baud generator
	// ------------------------------------------------------------
	localparam int unsigned TIMER_W            = 16;
	localparam logic [15:0] TIMER_MAX          = 16'hffff;
	localparam logic [16:0] TIMER_SPAN         = 17'h1_0000;
	localparam int unsigned PRE_W              = 6;
	localparam logic [1:0]  PRE_SEL_1          = 2'h0;
	localparam logic [1:0]  PRE_SEL_4          = 2'h1;
	localparam logic [1:0]  PRE_SEL_12         = 2'h2;
	localparam logic [1:0]  PRE_SEL_48         = 2'h3;
	localparam logic [5:0]  PRE_LAST_1         = 6'h00;
	localparam logic [5:0]  PRE_LAST_4         = 6'h03;
	localparam logic [5:0]  PRE_LAST_12        = 6'h0b;
	localparam logic [5:0]  PRE_LAST_48        = 6'h2f;

	// ------------------------------------------------------------
	// Character format
	// ------------------------------------------------------------
	localparam int unsigned DATA_W             = 8;
	localparam logic [2:0]  LEN_BASE           = 3'h4;
	localparam logic [1:0]  LEN_5              = 2'h0;
	localparam logic [1:0]  PAR_ODD            = 2'h0;
	localparam logic [1:0]  PAR_EVEN           = 2'h1;
	localparam logic [1:0]  PAR_MARK           = 2'h2;
	localparam logic [1:0]  PAR_SPACE          = 2'h3;

	// ------------------------------------------------------------
	// Receive FIFO
	// ------------------------------------------------------------
	localparam int unsigned FIFO_DEPTH         = 4;
	localparam logic [2:0]  RX_HOLD_MAX        = 3'h3;

	// ------------------------------------------------------------
	// State machines
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		TX_IDLE  = 3'b000,
		TX_START = 3'b001,
		TX_DATA  = 3'b010,
		TX_PAR   = 3'b011,
		TX_STOP1 = 3'b100,
		TX_STOP2 = 3'b101
	} tx_state_t;

	typedef enum logic [2:0] {
		RX_IDLE  = 3'b000,
		RX_START = 3'b001,
		RX_DATA  = 3'b010,
		RX_PAR   = 3'b011,
		RX_STOP  = 3'b100
	} rx_state_t;

endpackage

// *** byte_fifo.sv ***
`timescale 1ns/1ns
module byte_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 4
) (
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	input  wire logic                       in_valid,
	output logic                            in_ready,
	input  wire logic [WIDTH-1:0]           in_data,
	output logic                            out_valid,
	input  wire logic                       out_ready,
	output logic [WIDTH-1:0]                out_data,
	output logic [$clog2(DEPTH+1)-1:0]      level
);
	localparam int unsigned PW = $clog2(DEPTH);
	localparam int unsigned LW = $clog2(DEPTH+1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0]    wr_ptr_q;
	logic [PW-1:0]    rd_ptr_q;
	logic [LW-1:0]    level_q;
	logic             push;
	logic             pop;

	assign in_ready  = (level_q != LW'(DEPTH));
	assign out_valid = (level_q != '0);
	assign out_data  = mem_q[rd_ptr_q];
	assign level     = level_q;
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_ptr_q] <= in_data;
		end
	end

	// Pointers wrap at DEPTH, which need not be a power of two
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= (wr_ptr_q == PW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= (rd_ptr_q == PW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			level_q <= '0;
		end else if (push && !pop) begin
			level_q <= level_q + 1'b1;
		end else if (pop && !push) begin
			level_q <= level_q - 1'b1;
		end
	end

endmodule

// *** uart_brg.sv ***
`timescale 1ns/1ns
// Overview of operation
// - Transmitter and receiver run at the same time, each on its own.
// - Receiver holds up to three bytes; a fourth is lost and flags overflow.
// - A software write to the data buffer always loads the transmitter.
// - A data buffer read returns receive data only; transmit data is unreadable.
// - With interrupts enabled, a set transmit-done or receive-ready flag raises a request.
// - Transmit-done, receive-ready and overrun flags stay set until software clears each one itself.
// - Clearing receive-ready is ignored while bytes remain in the FIFO.
// - Baud timer is 16 bits, fed by core clock over prescaler 1, 4, 12 or 48.
// - Generator control holds enable, clock source select and prescaler select.
// - Nothing runs unless the baud generator is enabled.
// - Reload value is high byte and low byte of two registers.
// - Timer counts up per tick; on overflow from FFFF it takes the reload value.
// - Bit rate is core clock over (65536 minus reload), halved, over prescale.
// - Frame: low start, 5-8 data bits LSB first, optional parity/extra, 1-2 high stops.
// - Sending starts on a buffer write; transmit-done sets as the stop bit begins.
module uart_brg (
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	// Data buffer access
	input  wire logic        data_wr,
	input  wire logic [7:0]  data_wdata,
	input  wire logic        data_rd,
	output logic [7:0]       rx_data_q,
	// Control and status
	input  wire logic        int_enable,
	input  wire logic        tx_done_clr,
	input  wire logic        rx_ready_clr,
	input  wire logic        overrun_clr,
	output logic             tx_done_flag_q,
	output logic             rx_ready_flag_q,
	output logic             overrun_q,
	output logic             parity_err_q,
	output logic             rx_extra_q,
	output logic             tx_busy_q,
	output logic             irq_q,
	// Format
	input  wire logic [1:0]  data_len_sel,
	input  wire logic        parity_en,
	input  wire logic [1:0]  parity_sel,
	input  wire logic        extra_bit_en,
	input  wire logic        tx_extra_bit,
	input  wire logic        stop2_en,
	// Baud generator
	input  wire logic        brg_enable,
	input  wire logic        brg_clk_src,
	input  wire logic        brg_ext_tick,
	input  wire logic [1:0]  brg_prescale_sel,
	input  wire logic [7:0]  baud_reload_high,
	input  wire logic [7:0]  baud_reload_low,
	// Serial pins
	input  wire logic        rx_in,
	output logic             tx_q
);

	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	logic rst_meta_q;
	logic rst_n;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rst_meta_q <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n      <= rst_meta_q;
		end
	end

	// ------------------------------------------------------------
	// Baud generator
	// ------------------------------------------------------------
	logic [5:0]  pre_cnt_q;
	logic [5:0]  pre_last;
	logic        brg_tick;
	logic [15:0] timer_q;
	logic [15:0] reload;
	logic        ovf;
	logic        half_q;
	logic        bit_tick;
	logic [16:0] rx_half;

	assign reload = {baud_reload_high, baud_reload_low};

	always_comb begin
		unique case (brg_prescale_sel)
			uart_pkg::PRE_SEL_1:  pre_last = uart_pkg::PRE_LAST_1;
			uart_pkg::PRE_SEL_4:  pre_last = uart_pkg::PRE_LAST_4;
			uart_pkg::PRE_SEL_12: pre_last = uart_pkg::PRE_LAST_12;
			uart_pkg::PRE_SEL_48: pre_last = uart_pkg::PRE_LAST_48;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pre_cnt_q <= '0;
		end else if (!brg_enable || pre_cnt_q >= pre_last) begin
			pre_cnt_q <= '0;
		end else begin
			pre_cnt_q <= pre_cnt_q + 1'b1;
		end
	end

	// Source select: prescaled core clock, or an alternate tick enable
	assign brg_tick = brg_enable && (brg_clk_src ? brg_ext_tick : (pre_cnt_q >= pre_last));
	assign ovf      = brg_tick && (timer_q == uart_pkg::TIMER_MAX);
	assign bit_tick = ovf && half_q;
	assign rx_half  = uart_pkg::TIMER_SPAN - {1'b0, reload};

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			timer_q <= '0;
		end else if (!brg_enable) begin
			timer_q <= reload;
		end else if (ovf) begin
			timer_q <= reload;
		end else if (brg_tick) begin
			timer_q <= timer_q + 1'b1;
		end
	end

	// Two overflows per bit time give the divide by two
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			half_q <= 1'b0;
		end else if (!brg_enable) begin
			half_q <= 1'b0;
		end else if (ovf) begin
			half_q <= !half_q;
		end
	end

	// ------------------------------------------------------------
	// Shared format helpers
	// ------------------------------------------------------------
	logic [2:0] last_bit;
	logic       use_par;
	logic       use_stop2;

	assign last_bit  = uart_pkg::LEN_BASE + {1'b0, data_len_sel};
	assign use_par   = parity_en || extra_bit_en;
	// Second stop bit only exists for 6 to 8 data bits
	assign use_stop2 = stop2_en && (data_len_sel != uart_pkg::LEN_5);

	function automatic logic par_of(input logic [7:0] d, input logic [2:0] lb, input logic [1:0] sel);
		logic [7:0] m;
		m = d & ((8'h02 << lb) - 8'h01);
		unique case (sel)
			uart_pkg::PAR_ODD:   par_of = ~^m;
			uart_pkg::PAR_EVEN:  par_of = ^m;
			uart_pkg::PAR_MARK:  par_of = 1'b1;
			uart_pkg::PAR_SPACE: par_of = 1'b0;
		endcase
	endfunction

	// ------------------------------------------------------------
	// Transmitter
	// ------------------------------------------------------------
	uart_pkg::tx_state_t tx_st_q;
	logic [7:0]          tx_hold_q;
	logic                tx_pend_q;
	logic [7:0]          tx_sh_q;
	logic [2:0]          tx_bit_q;
	logic                tx_stop_enter;

	// Writes only ever reach the transmit side; a write during a frame waits
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tx_hold_q <= '0;
			tx_pend_q <= 1'b0;
		end else if (data_wr) begin
			tx_hold_q <= data_wdata;
			tx_pend_q <= 1'b1;
		end else if (tx_st_q == uart_pkg::TX_IDLE && bit_tick) begin
			tx_pend_q <= 1'b0;
		end
	end

	assign tx_stop_enter = bit_tick && tx_st_q != uart_pkg::TX_STOP1 && tx_st_q != uart_pkg::TX_STOP2
		&& ((tx_st_q == uart_pkg::TX_DATA && tx_bit_q == last_bit && !use_par) || tx_st_q == uart_pkg::TX_PAR);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tx_st_q  <= uart_pkg::TX_IDLE;
			tx_q     <= 1'b1;
			tx_sh_q  <= '0;
			tx_bit_q <= '0;
		end else if (!brg_enable) begin
			tx_st_q <= uart_pkg::TX_IDLE;
			tx_q    <= 1'b1;
		end else if (bit_tick) begin
			unique case (tx_st_q)
				uart_pkg::TX_IDLE: begin
					if (tx_pend_q) begin
						tx_st_q <= uart_pkg::TX_START;
						tx_sh_q <= tx_hold_q;
						tx_q    <= 1'b0;
					end
				end
				uart_pkg::TX_START: begin
					tx_st_q  <= uart_pkg::TX_DATA;
					tx_q     <= tx_sh_q[0];
					tx_bit_q <= '0;
				end
				uart_pkg::TX_DATA: begin
					if (tx_bit_q != last_bit) begin
						tx_bit_q <= tx_bit_q + 1'b1;
						tx_q     <= tx_sh_q[tx_bit_q + 3'h1];
					end else if (use_par) begin
						tx_st_q <= uart_pkg::TX_PAR;
						tx_q    <= parity_en ? par_of(tx_sh_q, last_bit, parity_sel) : tx_extra_bit;
					end else begin
						tx_st_q <= uart_pkg::TX_STOP1;
						tx_q    <= 1'b1;
					end
				end
				uart_pkg::TX_PAR: begin
					tx_st_q <= uart_pkg::TX_STOP1;
					tx_q    <= 1'b1;
				end
				uart_pkg::TX_STOP1: begin
					tx_st_q <= use_stop2 ? uart_pkg::TX_STOP2 : uart_pkg::TX_IDLE;
				end
				uart_pkg::TX_STOP2: begin
					tx_st_q <= uart_pkg::TX_IDLE;
				end
				default: begin
					tx_st_q <= uart_pkg::TX_IDLE;
					tx_q    <= 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tx_busy_q <= 1'b0;
		end else begin
			tx_busy_q <= tx_pend_q || data_wr || (tx_st_q != uart_pkg::TX_IDLE);
		end
	end

	// Set wins over a clear in the same cycle
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tx_done_flag_q <= 1'b0;
		end else if (brg_enable && tx_stop_enter) begin
			tx_done_flag_q <= 1'b1;
		end else if (tx_done_clr) begin
			tx_done_flag_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Receiver
	// ------------------------------------------------------------
	uart_pkg::rx_state_t rx_st_q;
	logic [16:0]         rx_cnt_q;
	logic [7:0]          rx_sh_q;
	logic [2:0]          rx_bit_q;
	logic                rx_prev_q;
	logic                rx_par_q;
	logic                rx_done;
	logic                rx_samp;
	logic                fifo_in_ready;
	logic                fifo_out_valid;
	logic [7:0]          fifo_out_data;
	logic [2:0]          fifo_level;
	logic                rx_room;
	logic                rx_push;

	// Sampling counts baud ticks itself so it centres on each bit
	assign rx_samp = brg_tick && (rx_cnt_q == 17'h0_0001);
	assign rx_done = rx_samp && rx_st_q == uart_pkg::RX_STOP && rx_in;
	assign rx_room = fifo_in_ready && (fifo_level < uart_pkg::RX_HOLD_MAX);
	assign rx_push = rx_done && rx_room;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rx_prev_q <= 1'b1;
		end else begin
			rx_prev_q <= rx_in;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rx_st_q  <= uart_pkg::RX_IDLE;
			rx_cnt_q <= '0;
			rx_sh_q  <= '0;
			rx_bit_q <= '0;
			rx_par_q <= 1'b0;
		end else if (!brg_enable) begin
			rx_st_q <= uart_pkg::RX_IDLE;
		end else if (rx_st_q == uart_pkg::RX_IDLE) begin
			if (rx_prev_q && !rx_in) begin
				rx_st_q  <= uart_pkg::RX_START;
				rx_cnt_q <= rx_half;
			end
		end else if (rx_samp) begin
			rx_cnt_q <= {rx_half[15:0], 1'b0};
			unique case (rx_st_q)
				uart_pkg::RX_START: begin
					rx_st_q  <= rx_in ? uart_pkg::RX_IDLE : uart_pkg::RX_DATA;
					rx_bit_q <= '0;
					rx_sh_q  <= '0;
				end
				uart_pkg::RX_DATA: begin
					rx_sh_q[rx_bit_q] <= rx_in;
					rx_bit_q          <= rx_bit_q + 1'b1;
					if (rx_bit_q == last_bit) begin
						rx_st_q <= use_par ? uart_pkg::RX_PAR : uart_pkg::RX_STOP;
					end
				end
				uart_pkg::RX_PAR: begin
					rx_par_q <= rx_in;
					rx_st_q  <= uart_pkg::RX_STOP;
				end
				default: begin
					rx_st_q <= uart_pkg::RX_IDLE;
				end
			endcase
		end else if (brg_tick) begin
			rx_cnt_q <= rx_cnt_q - 17'h0_0001;
		end
	end

	byte_fifo #(
		.WIDTH (uart_pkg::DATA_W),
		.DEPTH (uart_pkg::FIFO_DEPTH)
	) u_rx_fifo (
		.clk       (clk_sys),
		.rst_n     (rst_n),
		.in_valid  (rx_push),
		.in_ready  (fifo_in_ready),
		.in_data   (rx_sh_q),
		.out_valid (fifo_out_valid),
		.out_ready (data_rd),
		.out_data  (fifo_out_data),
		.level     (fifo_level)
	);

	// Only the receive side is ever visible at the read port
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rx_data_q <= '0;
		end else begin
			rx_data_q <= fifo_out_valid ? fifo_out_data : 8'h00;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			parity_err_q <= 1'b0;
			rx_extra_q   <= 1'b0;
		end else if (rx_push) begin
			parity_err_q <= parity_en && (rx_par_q != par_of(rx_sh_q, last_bit, parity_sel));
			rx_extra_q   <= rx_par_q;
		end
	end

	// A byte with no room is dropped; the FIFO contents stay intact
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			overrun_q <= 1'b0;
		end else if (rx_done && !rx_room) begin
			overrun_q <= 1'b1;
		end else if (overrun_clr) begin
			overrun_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rx_ready_flag_q <= 1'b0;
		end else if (rx_push) begin
			rx_ready_flag_q <= 1'b1;
		end else if (rx_ready_clr && fifo_level == 3'h0) begin
			rx_ready_flag_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Interrupt request
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= int_enable && (tx_done_flag_q || rx_ready_flag_q);
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	sequence stop_entry_s;
		brg_enable && tx_stop_enter;
	endsequence

	sequence done_seen_s;
		##1 (tx_done_flag_q && tx_st_q == uart_pkg::TX_STOP1 && tx_q);
	endsequence

	tx_done_set_a: assert property (stop_entry_s |-> done_seen_s)
		else $error("transmit done not set at stop bit start");
	tx_wr_pend_a: assert property (data_wr |=> tx_pend_q && tx_hold_q == $past(data_wdata))
		else $error("buffer write did not reach transmitter");
	rx_clr_block_a: assert property (rx_ready_flag_q && fifo_level != 3'h0 |=> rx_ready_flag_q)
		else $error("receive ready cleared with bytes held");
	rx_overrun_a: assert property (rx_done && fifo_level == 3'h3 |=> overrun_q && fifo_level == 3'h3)
		else $error("overrun not flagged or byte stored");
	flag_hold_a: assert property (tx_done_flag_q && !tx_done_clr |=> tx_done_flag_q)
		else $error("transmit done dropped without clear");
	irq_raise_a: assert property (int_enable && rx_ready_flag_q |=> irq_q)
		else $error("interrupt not raised");
	sequence both_idle_s;
		tx_q && tx_st_q == uart_pkg::TX_IDLE && rx_st_q == uart_pkg::RX_IDLE;
	endsequence

	brg_off_a: assert property (!brg_enable |=> both_idle_s)
		else $error("port active with generator off");
	timer_reload_a: assert property (ovf |=> timer_q == $past(reload))
		else $error("timer not reloaded on overflow");
	timer_count_a: assert property (brg_enable && brg_tick && !ovf |=> timer_q == $past(timer_q) + 16'h0001)
		else $error("timer did not count");
	// A change of source or prescale aborts the check, the period around it is legally irregular
	property pre_four_p;
		@(posedge clk_sys) disable iff (!rst_n || !brg_enable || brg_clk_src
			|| brg_prescale_sel != uart_pkg::PRE_SEL_4)
		brg_tick |-> ##1 !brg_tick [*3] ##1 brg_tick;
	endproperty

	pre_rate_a: assert property (pre_four_p)
		else $error("prescale by four wrong");

endmodule

// *** serial_node.sv ***
`timescale 1ns/1ns
module serial_node (
	input  wire logic clk,
	input  wire logic line_in,
	output logic      line_out,
	input  int        bit_cyc,
	input  int        nb
);
	logic [8:0] got[$];
	logic [8:0] raw;
	int         i;

	// ----------------------------------------
	// Receiver, one sample in the middle of each bit
	// ----------------------------------------
	initial line_out = 1'b1;
	always begin
		@(negedge line_in);
		raw = 9'h000;
		repeat (bit_cyc / 2) @(posedge clk);
		for (i = 0; i < nb; i++) begin
			repeat (bit_cyc) @(posedge clk);
			raw[i] = line_in;
		end
		repeat (bit_cyc) @(posedge clk);
		// A low stop bit marks the frame as broken
		if (line_in !== 1'b1)
			raw = 9'h1ff;
		got.push_back(raw);
	end

	// ----------------------------------------
	// Transmitter, eight data bits and one stop bit
	// ----------------------------------------
	task automatic send(input logic [7:0] b);
		int k;
		line_out <= 1'b0;
		repeat (bit_cyc) @(posedge clk);
		for (k = 0; k < 8; k++) begin
			line_out <= b[k];
			repeat (bit_cyc) @(posedge clk);
		end
		line_out <= 1'b1;
		repeat (bit_cyc) @(posedge clk);
	endtask
endmodule

// *** tb_uart_brg.sv ***
`timescale 1ns/1ns
module tb_uart_brg;
	logic       clk_sys, rstn, data_wr, data_rd, int_enable, tx_done_clr, rx_ready_clr, overrun_clr;
	logic [7:0] data_wdata, rx_data_q, baud_reload_high, baud_reload_low;
	logic       tx_done_flag_q, rx_ready_flag_q, overrun_q, parity_err_q, rx_extra_q, tx_busy_q, irq_q;
	logic [1:0] data_len_sel, parity_sel, brg_prescale_sel;
	logic       parity_en, extra_bit_en, tx_extra_bit, stop2_en, brg_enable, brg_clk_src, brg_ext_tick;
	logic       rx_in, tx_q, lo;
	int         err_count, num_checks, bc, nb, r, n;

	typedef struct {
		logic [7:0]  d;
		logic [1:0]  len;
		logic        xb;
		logic [1:0]  pre;
		logic [15:0] rl;
		int          bc;
		logic [8:0]  ex;
	} tx_row_t;

	// Bit times never drop below sixteen core clocks
	tx_row_t rows[4] = '{
		'{8'h5a, 2'h3, 1'b0, 2'h0, 16'hfff8, 16, 9'h05a},
		'{8'h13, 2'h0, 1'b1, 2'h1, 16'hfffe, 16, 9'h033},
		'{8'h2c, 2'h1, 1'b0, 2'h2, 16'hffff, 24, 9'h02c},
		'{8'h71, 2'h2, 1'b1, 2'h3, 16'hffff, 96, 9'h0f1}
	};
	logic [7:0] rx_exp[3] = '{8'h3c, 8'h96, 8'h4b};

	uart_brg i_dut (
		.clk_sys, .rstn, .data_wr, .data_wdata, .data_rd, .rx_data_q, .int_enable, .tx_done_clr,
		.rx_ready_clr, .overrun_clr, .tx_done_flag_q, .rx_ready_flag_q, .overrun_q, .parity_err_q,
		.rx_extra_q, .tx_busy_q, .irq_q, .data_len_sel, .parity_en, .parity_sel, .extra_bit_en,
		.tx_extra_bit, .stop2_en, .brg_enable, .brg_clk_src, .brg_ext_tick, .brg_prescale_sel,
		.baud_reload_high, .baud_reload_low, .rx_in, .tx_q
	);
	serial_node i_node (.clk(clk_sys), .line_in(tx_q), .line_out(rx_in), .bit_cyc(bc), .nb(nb));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task tick;
		@(posedge clk_sys);
		#5;
	endtask

	task chk_val(input logic [8:0] e, input logic [8:0] a);
		num_checks++;
		if (a !== e) begin
			err_count++;
			$display("ERROR t=%0t exp=%h got=%h", $time, e, a);
		end
	endtask

	task chk_bit(input logic e, input logic a);
		num_checks++;
		if (a !== e) begin
			err_count++;
			$display("ERROR t=%0t exp=%h got=%h", $time, e, a);
		end
	endtask

	// Bounded poll: 0 transmit done, 1 receive ready, 2 partner caught a frame
	task automatic wait_cond(input int w);
		for (n = 0; n < 4000; n++) begin
			if (w == 0 && tx_done_flag_q === 1'b1)
				break;
			if (w == 1 && rx_ready_flag_q === 1'b1)
				break;
			if (w == 2 && i_node.got.size() > 0)
				break;
			tick;
		end
		if (n == 4000) begin
			err_count++;
			$display("ERROR t=%0t wait=%h timed out", $time, w);
		end
	endtask

	task send_byte(input logic [7:0] b);
		data_wdata = b;
		data_wr = 1'b1;
		tick;
		data_wr = 1'b0;
	endtask

	task clear_all;
		{tx_done_clr, rx_ready_clr, overrun_clr} = 3'b111;
		tick;
		{tx_done_clr, rx_ready_clr, overrun_clr} = 3'b000;
		repeat (3) tick;
	endtask

	task wrap_up;
		$display("checks=%0d errors=%0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	// Alternate tick source: one pulse every fourth cycle while it is selected
	initial begin
		brg_ext_tick = 1'b0;
		forever begin
			repeat (3) tick;
			brg_ext_tick = brg_clk_src;
			tick;
			brg_ext_tick = 1'b0;
		end
	end

	// Whole run is well under ten thousand cycles
	initial begin
		repeat (30000) @(posedge clk_sys);
		err_count++;
		wrap_up;
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{data_wr, data_rd, int_enable, tx_done_clr, rx_ready_clr, overrun_clr, data_wdata} = '0;
		{data_len_sel, parity_en, parity_sel, extra_bit_en, tx_extra_bit, stop2_en} = '0;
		{brg_enable, brg_clk_src, brg_prescale_sel} = '0;
		{baud_reload_high, baud_reload_low} = 16'hfff8;
		err_count = 0;
		num_checks = 0;
		bc = 16;
		nb = 8;
		rstn = 1'b0;
		repeat (16) @(posedge clk_sys);
		#5 rstn = 1'b1;
		repeat (4) tick;
		chk_bit(1'b1, tx_q);
		chk_bit(1'b0, tx_done_flag_q);
		chk_bit(1'b0, rx_ready_flag_q);
		chk_bit(1'b0, irq_q);
		chk_val(9'h000, {1'b0, rx_data_q});

		for (r = 0; r < 4; r++) begin
			data_len_sel = rows[r].len;
			extra_bit_en = rows[r].xb;
			tx_extra_bit = 1'b1;
			brg_prescale_sel = rows[r].pre;
			{baud_reload_high, baud_reload_low} = rows[r].rl;
			bc = rows[r].bc;
			nb = 5 + int'(rows[r].len) + int'(rows[r].xb);
			brg_enable = 1'b1;
			tick;
			send_byte(rows[r].d);
			chk_bit(1'b1, tx_busy_q);
			wait_cond(0);
			chk_bit(1'b1, tx_q);
			wait_cond(2);
			chk_val(rows[r].ex, i_node.got.pop_front());
			repeat (2 * bc) tick;
			chk_bit(1'b0, tx_busy_q);
			chk_bit(1'b1, tx_done_flag_q);
			clear_all;
			chk_bit(1'b0, tx_done_flag_q);
		end

		// Generator off: the byte waits and the line stays idle
		{data_len_sel, extra_bit_en, brg_prescale_sel, brg_enable} = {2'h3, 1'b0, 2'h0, 1'b0};
		{baud_reload_high, baud_reload_low} = 16'hfff8;
		bc = 16;
		nb = 8;
		tick;
		send_byte(8'hc3);
		lo = 1'b0;
		repeat (300) begin
			tick;
			lo = lo | ~tx_q;
		end
		chk_bit(1'b0, lo);
		chk_bit(1'b0, tx_done_flag_q);
		brg_enable = 1'b1;
		wait_cond(2);
		chk_val(9'h0c3, i_node.got.pop_front());
		repeat (2 * bc) tick;
		clear_all;

		// Alternate tick source, odd parity, two stop bits; 0x69 has even weight so parity is 1
		{brg_clk_src, parity_en, parity_sel, stop2_en} = {1'b1, 1'b1, uart_pkg::PAR_ODD, 1'b1};
		{baud_reload_high, baud_reload_low} = 16'hfffe;
		nb = 9;
		tick;
		send_byte(8'h69);
		wait_cond(2);
		chk_val(9'h169, i_node.got.pop_front());
		repeat (bc) tick;
		chk_bit(1'b1, tx_busy_q);
		repeat (bc) tick;
		chk_bit(1'b0, tx_busy_q);
		{brg_clk_src, parity_en, stop2_en} = 3'b000;
		{baud_reload_high, baud_reload_low} = 16'hfff8;
		nb = 8;
		clear_all;

		// Both directions at once, then fill the receiver past three bytes
		int_enable = 1'b1;
		fork
			send_byte(8'ha5);
			i_node.send(8'h3c);
		join
		wait_cond(2);
		chk_val(9'h0a5, i_node.got.pop_front());
		wait_cond(1);
		repeat (2) tick;
		chk_val(9'h03c, {1'b0, rx_data_q});
		chk_bit(1'b1, irq_q);
		chk_bit(1'b0, parity_err_q);
		chk_bit(1'b0, rx_extra_q);
		i_node.send(8'h96);
		i_node.send(8'h4b);
		rx_ready_clr = 1'b1;
		tick;
		rx_ready_clr = 1'b0;
		tick;
		chk_bit(1'b1, rx_ready_flag_q);
		chk_bit(1'b0, overrun_q);
		i_node.send(8'he1);
		repeat (2) tick;
		chk_bit(1'b1, overrun_q);
		for (r = 0; r < 3; r++) begin
			chk_val({1'b0, rx_exp[r]}, {1'b0, rx_data_q});
			data_rd = 1'b1;
			tick;
			data_rd = 1'b0;
			repeat (2) tick;
		end
		chk_val(9'h000, {1'b0, rx_data_q});
		chk_bit(1'b1, rx_ready_flag_q);
		chk_bit(1'b1, irq_q);
		clear_all;
		chk_bit(1'b0, rx_ready_flag_q);
		chk_bit(1'b0, overrun_q);
		chk_bit(1'b0, irq_q);
		wrap_up;
	end
endmodule
